// ### include/adc_seq_map.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
// register offsets (word index on the plain port)
`define ADDR_MODE 4'h0
`define ADDR_CHAN 4'h1
`define ADDR_RESULT 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_PF_MODE 4'h4
`define ADDR_PF_THR 4'h5
// mode register fields
`define MODE_RUN_BIT 7
`define MODE_FR_HI 5
`define MODE_FR_LO 3
`define MODE_PWR_BIT 0
`define MODE_RESET 8'h00
`define CHAN_RESET 8'h00
// status register fields
`define STAT_FLAG_BIT 0
`define STAT_BUSY_BIT 1
// timing
`define POWER_SETTLE_NS 14000
`define CLK_PERIOD_NS 10
`define START_DELAY_CYC 8
`endif

// ### include/adc_seq_pkg.sv
// types of the converter control
package adc_seq_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DELAY = 2'b01,
      ST_SAMPLE = 2'b10,
      ST_CONVERT = 2'b11
   } conv_state_type;
endpackage

// ### core/adc_seq_timer.sv
// conversion timer: counts a load value down and flags its expiry
`timescale 1ns/10ps
module adc_seq_timer #(
   parameter int CW = 12
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // control
   input wire logic i_load,
   input wire logic [CW-1:0] i_value,
   // status
   output logic o_expired
);
   logic [CW-1:0] count_q;

   // reload on request, otherwise count down to zero
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         count_q <= '0;
      end else if (i_load) begin
         count_q <= i_value;
      end else if (count_q != '0) begin
         count_q <= count_q - 1'b1;
      end
   end

   // one cycle before the count reaches zero
   assign o_expired = (count_q == {{(CW-1){1'b0}}, 1'b1});
endmodule

// ### core/adc_seq_ctrl.sv
// control and sequencing logic of an eight-channel successive-approximation converter
//
// Behaviour
// R1: channel write never clears done flag
// R2: channel change may finish old conversion first
// R3: software clears done flag before restarting
// R4: software waits 14 us power-on before run
// R5: software discards first result after start
// R6: mode or channel write may spoil result
// R7: software reads result before mode/channel writes
// R8: sampling time from mode; start delay first
// R9: sampling lasts one sixth of conversion time
// R10: no access while main oscillator stopped
// R11: no shared port access during conversion
// R12: result read delays pending result write
// R13: mode/channel write beats conversion end
// R14: run bit at mode bit 7; 0 stops
// R15: result, flag and request in one cycle
`timescale 1ns/10ps
`include "adc_seq_map.svh"
module adc_seq_ctrl #(
   parameter int RES_W = 10,
   parameter int CW = 12,
   parameter int BASE_CYC = 96
) (
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST_B,
   // register port
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [15:0] O_RDATA,
   // analog front end
   input wire logic [RES_W-1:0] I_SAR_DATA,
   output logic [2:0] O_CHAN_SEL,
   output logic O_SAMPLE,
   output logic O_POWER_ON,
   // event
   output logic O_CONV_DONE_IRQ
);
   // ==========================================================
   // register state
   logic [7:0] converter_mode_reg_q;
   logic [7:0] channel_select_reg_q;
   logic [7:0] powerfail_mode_reg_q;
   logic [7:0] powerfail_threshold_reg_q;
   logic [RES_W-1:0] conversion_result_reg_q;
   logic [RES_W-1:0] pend_result_q;
   logic pend_q;
   logic conv_done_irq_flag_q;
   adc_seq_pkg::conv_state_type state_q;
   logic [CW-1:0] delay_q;
   logic [CW-1:0] samp_q;
   logic [CW-1:0] conv_q;
   logic timer_load;
   logic [CW-1:0] timer_value;
   logic timer_expired;

   logic wr_mode;
   logic wr_chan;
   logic rd_result;
   logic conv_end;
   logic ctrl_wr;
   logic run_bit;
   logic power_on_bit;

   // conversion time in cycles from the three-bit time code
   function automatic logic [CW-1:0] conv_cycles(input logic [2:0] code);
      conv_cycles = CW'(BASE_CYC * (int'(code) + 1));
   endfunction

   // ==========================================================
   // access decode
   assign wr_mode = I_WR && (I_ADDR == `ADDR_MODE);
   assign wr_chan = I_WR && (I_ADDR == `ADDR_CHAN);
   assign rd_result = I_RD && (I_ADDR == `ADDR_RESULT);
   assign ctrl_wr = wr_mode || wr_chan;
   assign run_bit = converter_mode_reg_q[`MODE_RUN_BIT];
   assign power_on_bit = converter_mode_reg_q[`MODE_PWR_BIT];
   assign conv_end = (state_q == adc_seq_pkg::ST_CONVERT) && timer_expired;

   // ==========================================================
   // software registers
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         converter_mode_reg_q <= `MODE_RESET;
         channel_select_reg_q <= `CHAN_RESET;
         powerfail_mode_reg_q <= 8'h00;
         powerfail_threshold_reg_q <= 8'h00;
      end else if (I_WR) begin
         case (I_ADDR)
            `ADDR_MODE: converter_mode_reg_q <= I_WDATA; // [R14]
            `ADDR_CHAN: channel_select_reg_q <= {5'h00, I_WDATA[2:0]};
            `ADDR_PF_MODE: powerfail_mode_reg_q <= I_WDATA;
            `ADDR_PF_THR: powerfail_threshold_reg_q <= I_WDATA;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // sequencer: start delay, sampling, conversion
   always_comb begin
      timer_load = 1'b0;
      timer_value = '0;
      case (state_q)
         adc_seq_pkg::ST_IDLE: begin
            timer_load = run_bit;
            timer_value = CW'(`START_DELAY_CYC); // [R8]
         end
         adc_seq_pkg::ST_DELAY: begin
            timer_load = timer_expired;
            timer_value = samp_q; // [R9]
         end
         adc_seq_pkg::ST_SAMPLE: begin
            timer_load = timer_expired;
            timer_value = CW'(conv_q - samp_q);
         end
         adc_seq_pkg::ST_CONVERT: begin
            timer_load = timer_expired || ctrl_wr;
            timer_value = samp_q;
         end
         default: ;
      endcase
      // a control write restarts sampling; the start delay runs out untouched
      if (ctrl_wr && (state_q == adc_seq_pkg::ST_SAMPLE ||
            state_q == adc_seq_pkg::ST_CONVERT)) begin
         timer_load = 1'b1;
         timer_value = samp_q;
      end
   end

   // conversion and sampling phase lengths derived from the mode's time code
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         conv_q <= '0;
         samp_q <= '0;
      end else begin
         conv_q <= conv_cycles(converter_mode_reg_q[`MODE_FR_HI:`MODE_FR_LO]); // [R8]
         samp_q <= CW'(conv_cycles(converter_mode_reg_q[`MODE_FR_HI:`MODE_FR_LO]) / 6); // [R9]
      end
   end

   // state register
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         state_q <= adc_seq_pkg::ST_IDLE;
      end else if (!run_bit) begin
         state_q <= adc_seq_pkg::ST_IDLE; // [R14]
      end else begin
         case (state_q)
            adc_seq_pkg::ST_IDLE: state_q <= adc_seq_pkg::ST_DELAY;
            adc_seq_pkg::ST_DELAY: if (timer_expired) state_q <= adc_seq_pkg::ST_SAMPLE;
            adc_seq_pkg::ST_SAMPLE: if (ctrl_wr) begin
               state_q <= adc_seq_pkg::ST_SAMPLE;
            end else if (timer_expired) begin
               state_q <= adc_seq_pkg::ST_CONVERT;
            end
            adc_seq_pkg::ST_CONVERT: if (timer_expired || ctrl_wr) begin
               state_q <= adc_seq_pkg::ST_SAMPLE; // restart sampling for the next conversion
            end
            default: state_q <= adc_seq_pkg::ST_IDLE;
         endcase
      end
   end

   // shared countdown timer
   adc_seq_timer #(
      .CW(CW)
   ) u_timer (
      .i_clk(I_CLK_SYS),
      .i_rst_b(I_RST_B),
      .i_load(timer_load),
      .i_value(timer_value),
      .o_expired(timer_expired)
   );

   // ==========================================================
   // result register with read priority
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         conversion_result_reg_q <= '0;
         pend_result_q <= '0;
         pend_q <= 1'b0;
      end else if (conv_end && !ctrl_wr) begin // [R13] [R6]
         if (rd_result) begin
            pend_result_q <= I_SAR_DATA; // [R12]
            pend_q <= 1'b1;
         end else begin
            conversion_result_reg_q <= I_SAR_DATA; // [R15]
            pend_q <= 1'b0;
         end
      end else if (pend_q && !rd_result) begin
         conversion_result_reg_q <= pend_result_q; // [R12]
         pend_q <= 1'b0;
      end
   end

   // done flag: set wins over a software clear; channel writes leave it
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         conv_done_irq_flag_q <= 1'b0;
      end else if (conv_end && !ctrl_wr) begin
         conv_done_irq_flag_q <= 1'b1; // [R15] [R2]
      end else if (I_WR && I_ADDR == `ADDR_STATUS && !I_WDATA[`STAT_FLAG_BIT]) begin
         conv_done_irq_flag_q <= 1'b0; // [R1]
      end
   end

   // ==========================================================
   // outputs
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_CONV_DONE_IRQ <= 1'b0;
         O_SAMPLE <= 1'b0;
         O_POWER_ON <= 1'b0;
         O_CHAN_SEL <= 3'h0;
      end else begin
         O_CONV_DONE_IRQ <= conv_end && !ctrl_wr; // [R15] [R13]
         O_SAMPLE <= (state_q == adc_seq_pkg::ST_SAMPLE) && !ctrl_wr;
         O_POWER_ON <= power_on_bit;
         O_CHAN_SEL <= channel_select_reg_q[2:0];
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_RDATA <= 16'h0000;
      end else if (I_RD) begin
         case (I_ADDR)
            `ADDR_MODE: O_RDATA <= {8'h00, converter_mode_reg_q};
            `ADDR_CHAN: O_RDATA <= {8'h00, channel_select_reg_q};
            `ADDR_RESULT: O_RDATA <= 16'(conversion_result_reg_q); // [R12]
            `ADDR_STATUS: O_RDATA <= {14'h0000, state_q != adc_seq_pkg::ST_IDLE,
               conv_done_irq_flag_q};
            `ADDR_PF_MODE: O_RDATA <= {8'h00, powerfail_mode_reg_q};
            `ADDR_PF_THR: O_RDATA <= {8'h00, powerfail_threshold_reg_q};
            default: O_RDATA <= 16'h0000;
         endcase
      end else begin
         O_RDATA <= 16'h0000;
      end
   end

   // ==========================================================
   // checks
   a_irq_with_flag: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B) // [R15]
      O_CONV_DONE_IRQ |-> conv_done_irq_flag_q)
      else $error("request without flag");
   a_chan_keeps_flag: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B) // [R1]
      (wr_chan && conv_done_irq_flag_q) |=> conv_done_irq_flag_q)
      else $error("channel write cleared flag");
   a_write_blocks_end: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B) // [R13]
      (conv_end && ctrl_wr) |=> !O_CONV_DONE_IRQ)
      else $error("request despite control write");
   a_read_defers: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B) // [R12]
      (conv_end && !ctrl_wr && rd_result) |=> pend_q)
      else $error("result not deferred");
   a_stop_idle: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B) // [R14]
      !run_bit |=> state_q == adc_seq_pkg::ST_IDLE)
      else $error("run bit clear did not stop");
   a_start_delay: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B) // [R8]
      (state_q == adc_seq_pkg::ST_IDLE && run_bit) |=> !O_SAMPLE [*2])
      else $error("sampling without start delay");
endmodule

// ### test/adc_front_end_model.sv
// behavioural model of the analog sampling front end
`timescale 1ns/10ps
module adc_front_end_model #(
   parameter int RES_W = 10
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // converter side
   input wire logic [2:0] i_chan_sel,
   input wire logic i_sample,
   input wire logic i_power_on,
   output logic [RES_W-1:0] o_sar_data
);
   logic [2:0] held_q;
   logic alt_q;
   // ==========
   // input tracked while sampling and held afterwards; no digital port traffic on the pins
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         held_q <= 3'h0;
         alt_q <= 1'b0;
      end else begin
         alt_q <= ~alt_q;
         if (i_sample) begin
            held_q <= i_chan_sel;
         end
      end
   end
   // code per channel; unpowered gives a toggling pattern
   assign o_sar_data = i_power_on ? RES_W'({held_q, 7'h5a}) : {RES_W{alt_q}};
endmodule

// ### test/adc_sequencing_control_tb_top.sv
// self-checking bench of the converter control
`timescale 1ns/10ps
`include "adc_seq_map.svh"
module adc_sequencing_control_tb_top;
   localparam int BASE = 12;
   localparam int PWR_WAIT = `POWER_SETTLE_NS / `CLK_PERIOD_NS;
   typedef struct {logic we; logic [3:0] a; logic [7:0] d; logic [15:0] e;} row_type;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd_s = 1'b0;
   logic [15:0] rdata;
   logic [15:0] r;
   logic [9:0] sar;
   logic [2:0] chan;
   logic smp;
   logic pwr;
   logic irq;
   int error_cnt = 0;
   int tests_run = 0;
   int n;
   int p;
   row_type rows [9] = '{
      '{1'b0, `ADDR_MODE, 8'h00, 16'h0000}, '{1'b0, `ADDR_STATUS, 8'h00, 16'h0000},
      '{1'b0, `ADDR_RESULT, 8'h00, 16'h0000}, '{1'b1, `ADDR_PF_MODE, 8'ha5, 16'h00a5},
      '{1'b1, `ADDR_PF_THR, 8'h3c, 16'h003c}, '{1'b1, `ADDR_CHAN, 8'h06, 16'h0006},
      '{1'b1, `ADDR_RESULT, 8'hff, 16'h0000}, '{1'b1, 4'h9, 8'h77, 16'h0000},
      '{1'b1, `ADDR_MODE, 8'h28, 16'h0028}};
   // ==========
   // clock, design and front end; clock never stops
   always #5 clk = ~clk;
   adc_seq_ctrl #(.BASE_CYC(BASE)) i_adc_seq_ctrl (.I_CLK_SYS(clk), .I_RST_B(rst_b),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd_s), .O_RDATA(rdata),
      .I_SAR_DATA(sar), .O_CHAN_SEL(chan), .O_SAMPLE(smp), .O_POWER_ON(pwr),
      .O_CONV_DONE_IRQ(irq));
   adc_front_end_model i_adc_front_end_model (.i_clk(clk), .i_rst_b(rst_b),
      .i_chan_sel(chan), .i_sample(smp), .i_power_on(pwr), .o_sar_data(sar));
   // ==========
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_irq(output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (irq !== 1'b1 && k < 400);
      chk(16'(irq), 16'h0001);
   endtask
   function automatic logic [15:0] res(input logic [2:0] c);
      return {6'h00, c, 7'h5a};
   endfunction
   task automatic tally_and_finish;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end
   // ==========
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      #1 chk(16'({chan, smp, pwr, irq}), 16'h0000);
      foreach (rows[i]) begin
         if (rows[i].we) begin
            wr_reg(rows[i].a, rows[i].d);
         end
         rd_reg(rows[i].a, r);
         chk(r, rows[i].e);
      end
      chk(16'(chan), 16'h0006);
      // start-up: power on, settle, run
      wr_reg(`ADDR_CHAN, 8'h03);
      wr_reg(`ADDR_MODE, 8'h01);
      @(posedge clk);
      #1 chk(16'(pwr), 16'h0001);
      repeat (PWR_WAIT) @(posedge clk);
      wr_reg(`ADDR_MODE, 8'h89);
      n = 0;
      while (smp !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1 n++;
      end
      chk(16'(n >= `START_DELAY_CYC), 16'h0001);
      p = 0;
      while (smp === 1'b1 && p < 50) begin
         @(posedge clk);
         #1 p++;
      end
      chk(16'(p), 16'(BASE * 2 / 6));
      wait_irq(n);
      rd_reg(`ADDR_STATUS, r);
      chk(16'(r[0]), 16'h0001);
      wait_irq(n);
      rd_reg(`ADDR_RESULT, r);
      chk(r, res(3'h3));
      wr_reg(`ADDR_CHAN, 8'h05);
      rd_reg(`ADDR_STATUS, r);
      chk(16'(r[0]), 16'h0001);
      chk(16'(chan), 16'h0005);
      // stop, clear flag, resume
      wr_reg(`ADDR_MODE, 8'h09);
      repeat (60) @(posedge clk);
      rd_reg(`ADDR_STATUS, r);
      chk(16'({r[1], smp}), 16'h0000);
      wr_reg(`ADDR_STATUS, 8'h00);
      rd_reg(`ADDR_STATUS, r);
      chk(r, 16'h0000);
      wr_reg(`ADDR_MODE, 8'h89);
      wait_irq(n);
      wait_irq(n);
      rd_reg(`ADDR_RESULT, r);
      chk(r, res(3'h5));
      // a read that collides with the result write, then a read of the deferred result
      wr_reg(`ADDR_CHAN, 8'h02);
      repeat (23) @(posedge clk);
      addr <= `ADDR_RESULT;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(16'(irq), 16'h0001);
      chk(rdata, res(3'h5));
      rd_reg(`ADDR_RESULT, r);
      chk(r, res(3'h2));
      // mode write in the conversion-end cycle, flag cleared beforehand
      wait_irq(n);
      wr_reg(`ADDR_STATUS, 8'h00);
      repeat (21) @(posedge clk);
      addr <= `ADDR_MODE;
      wdata <= 8'h89;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1 chk(16'(irq), 16'h0000);
      n = 0;
      repeat (6) begin
         @(posedge clk);
         #1 n += int'(irq === 1'b1);
      end
      chk(16'(n), 16'h0000);
      rd_reg(`ADDR_STATUS, r);
      chk(16'(r[0]), 16'h0000);
      // reset in mid-run clears outputs and registers
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      #1 chk(16'({chan, smp, pwr, irq}), 16'h0000);
      rd_reg(`ADDR_MODE, r);
      chk(r, 16'(`MODE_RESET));
      rd_reg(`ADDR_STATUS, r);
      chk(r, 16'h0000);
      tally_and_finish();
   end
endmodule
